// >>> testbench.sv
// Purpose: Register-level tests of the 8-bit timer
// Assumes: Inputs change at the falling edge
// Notes:   Tick counts measured with the clock started and stopped by writes
`timescale 1ns/1ps
module testbench;
    localparam logic [5:0] CMP = tmr8_pkg::COMPARE_VALUE_OFS;
    localparam logic [5:0] CNT = tmr8_pkg::COUNTER_VALUE_OFS;
    localparam logic [5:0] CTL = tmr8_pkg::CONTROL_OFS;
    localparam logic [5:0] FLG = tmr8_pkg::IRQ_FLAGS_OFS;
    localparam logic [5:0] MSK = tmr8_pkg::IRQ_MASK_OFS;
    logic                   clk_i = 1'b0;
    logic                   arst_n_i = 1'b0;
    tmr8_pkg::tmr8_io_req_t req = '0;
    tmr8_pkg::tmr8_io_rsp_t rsp;
    logic                   pin = 1'b0, gie = 1'b0, cack = 1'b0, oack = 1'b0;
    logic                   oa = 1'b0, oa_en = 1'b0, latch = 1'b0, legacy = 1'b0;
    logic                   cirq, oirq, ob, opin, oen;
    logic [7:0]             v;
    int                     bad_count = 0, cmp_count = 0, cyc = 0;
    int                     div [6] = '{1, 1, 8, 64, 256, 1024};
    logic [5:0]             ofs [6] = '{CMP, CNT, CTL, FLG, MSK, 6'h30};
    always #50 clk_i = ~clk_i;
    tmr8_timer tmr8_timer_i (.clk_i, .arst_n_i, .io_req_i(req), .io_rsp_o(rsp),
        .ext_count_pin_i(pin), .global_irq_en_i(gie), .compare_vec_ack_i(cack),
        .overflow_vec_ack_i(oack), .compare_out_a_i(oa), .compare_out_a_en_i(oa_en),
        .port_latch_bit_i(latch), .legacy_mode_i(legacy), .compare_irq_o(cirq),
        .overflow_irq_o(oirq), .compare_out_b_o(ob), .compare_out_pin_o(opin),
        .compare_out_pin_en_o(oen));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Idle cycle at the end so a strobe is never re-raised in one step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk_i);
        req.wr = 1'b0;
        @(negedge clk_i);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk_i);
        v = rsp.rdata;
        check("valid", 8'h01, rsp.valid);
        req.rd = 1'b0;
        @(negedge clk_i);
    endtask : rd
    task automatic run(input int n);
        repeat (n) @(negedge clk_i);
    endtask : run
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        run(10);
        arst_n_i = 1'b1;
        run(1);
        foreach (ofs[i]) begin
            rd(ofs[i]);
            check("reset value", 8'h00, v);
        end
        wr(CMP, 8'hA5);
        rd(CMP);
        check("compare reg", 8'hA5, v);
        wr(CNT, 8'h5A);
        rd(CNT);
        check("counter reg", 8'h5A, v);
        wr(MSK, 8'hC0);
        rd(MSK);
        check("mask reg", 8'hC0, v);
        wr(6'h30, 8'hFF);
        rd(6'h30);
        check("unmapped", 8'h00, v);
        wr(CTL, 8'h87);
        rd(CTL);
        check("control reg", 8'h07, v);
        wr(CTL, 8'h00);
        $display("test registers done");
        for (int c = 1; c < 6; c++) begin
            wr(CNT, 8'h00);
            wr(CTL, 8'(c));
            run(4 * div[c] - 2);
            wr(CTL, 8'h00);
            rd(CNT);
            check("prescale count", 8'h04, v);
        end
        $display("test prescaler done");
        wr(CNT, 8'h00);
        wr(CMP, 8'h03);
        wr(MSK, 8'h80);
        gie = 1'b1;
        wr(CTL, 8'h01);
        run(6);
        wr(CTL, 8'h00);
        rd(FLG);
        check("compare flag", 8'h80, v);
        check("compare irq", 8'h01, cirq);
        gie = 1'b0;
        #1 check("compare irq off", 8'h00, cirq);
        gie = 1'b1;
        wr(FLG, 8'h40);
        rd(FLG);
        check("flag keep", 8'h80, v);
        wr(FLG, 8'h80);
        rd(FLG);
        check("flag clear", 8'h00, v);
        wr(CNT, 8'h00);
        wr(CTL, 8'h01);
        run(6);
        wr(CTL, 8'h00);
        pulse(cack);
        rd(FLG);
        check("vector clear", 8'h00, v);
        wr(CNT, 8'h03);
        wr(CTL, 8'h01);
        run(6);
        wr(CTL, 8'h00);
        rd(FLG);
        check("match blocked", 8'h00, v);
        $display("test compare done");
        wr(CMP, 8'h80);
        wr(CNT, 8'hFD);
        wr(MSK, 8'h40);
        wr(CTL, 8'h01);
        run(4);
        wr(CTL, 8'h00);
        rd(FLG);
        check("overflow flag", 8'h40, v);
        check("overflow irq", 8'h01, oirq);
        pulse(oack);
        rd(FLG);
        check("overflow vector", 8'h00, v);
        wr(CNT, 8'hF0);
        wr(CTL, 8'h41);
        run(30);
        wr(CTL, 8'h00);
        rd(FLG);
        check("pc no top flag", 8'h00, v & 8'h40);
        wr(CTL, 8'h41);
        run(300);
        wr(CTL, 8'h00);
        rd(FLG);
        check("pc bottom flag", 8'h40, v & 8'h40);
        wr(FLG, 8'hC0);
        wr(CMP, 8'h10);
        wr(CNT, 8'h00);
        wr(CTL, 8'h09);
        run(60);
        wr(CTL, 8'h00);
        rd(CNT);
        check("ctc top", 8'h0B, v);
        rd(FLG);
        check("ctc no overflow", 8'h00, v & 8'h40);
        wr(CNT, 8'hFE);
        wr(CTL, 8'h09);
        run(1);
        wr(CTL, 8'h00);
        rd(FLG);
        check("ctc max overflow", 8'h40, v & 8'h40);
        wr(FLG, 8'h40);
        wr(CNT, 8'hFE);
        wr(CTL, 8'h49);
        run(1);
        wr(CTL, 8'h00);
        rd(CNT);
        check("fast wrap", 8'h01, v);
        rd(FLG);
        check("fast overflow", 8'h40, v & 8'h40);
        $display("test modes done");
        for (int c = 6; c < 8; c++) begin
            pin = 1'b1;
            wr(CNT, 8'h00);
            wr(CTL, 8'(c));
            repeat (5) begin
                run(4);
                pin = 1'b0;
                run(4);
                pin = 1'b1;
            end
            run(4);
            wr(CTL, 8'h00);
            rd(CNT);
            check("pin count", 8'h05, v);
        end
        $display("test pin done");
        check("pin enable off", 8'h00, oen);
        oa_en = 1'b1;
        wr(CTL, 8'h10);
        for (int b = 0; b < 2; b++) begin
            if (b == 1) begin
                wr(CNT, 8'h00);
                wr(CMP, 8'h02);
                wr(CTL, 8'h11);
                run(2);
                wr(CTL, 8'h10);
                check("compare out", 8'h01, ob);
            end
            for (int k = 0; k < 4; k++) begin
                latch = k[1];
                oa = k[0];
                run(2);
                check("mod pin", latch ? (oa | b[0]) : (oa & b[0]), opin);
            end
        end
        legacy = 1'b1;
        latch = 1'b0;
        oa = 1'b0;
        run(2);
        check("legacy pin", 8'h01, opin);
        check("pin enable", 8'h01, oen);
        $display("test modulator done");
        test_done();
    end
endmodule : testbench

// >>> tmr8_clk_src.sv
// Purpose: Counter tick source: prescaler or external count pin
// Assumes: Pin is asynchronous to clk_i
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/1ps
module tmr8_clk_src (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [2:0] clock_select_i,
    input  wire logic       ext_count_pin_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [9:0] presc;
        logic       sync1;
        logic       sync2;
        logic       last;
    } tmr8_cs_state_t;

    tmr8_cs_state_t s_q, s_d;
    logic           tick_c;

    always_comb begin
        s_d       = s_q;
        s_d.presc = s_q.presc + 10'h001;
        s_d.sync1 = ext_count_pin_i;
        s_d.sync2 = s_q.sync1;
        s_d.last  = s_q.sync2;
        case (clock_select_i)
            3'h1:    tick_c = 1'b1;
            3'h2:    tick_c = (s_q.presc & tmr8_pkg::DIV8_MASK) == tmr8_pkg::DIV8_MASK;
            3'h3:    tick_c = (s_q.presc & tmr8_pkg::DIV64_MASK) == tmr8_pkg::DIV64_MASK;
            3'h4:    tick_c = (s_q.presc & tmr8_pkg::DIV256_MASK) == tmr8_pkg::DIV256_MASK;
            3'h5:    tick_c = s_q.presc == tmr8_pkg::DIV1024_MASK;
            // Pin read regardless of its direction
            3'h6,
            3'h7:    tick_c = s_q.last & ~s_q.sync2;
            default: tick_c = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = tick_c;
endmodule : tmr8_clk_src

// >>> tmr8_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer slice
// Assumes: Byte-wide CPU I/O register port, one clock
// Notes:   Offsets are I/O addresses
package tmr8_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] COMPARE_VALUE_OFS = 6'h23;
    localparam logic [5:0] COUNTER_VALUE_OFS = 6'h24;
    localparam logic [5:0] CONTROL_OFS       = 6'h25;
    localparam logic [5:0] IRQ_FLAGS_OFS     = 6'h36;
    localparam logic [5:0] IRQ_MASK_OFS      = 6'h37;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam int         CMP_BIT           = 7;
    localparam int         OVF_BIT           = 6;
    localparam int         WGM_LO_BIT        = 6;
    localparam int         WGM_HI_BIT        = 3;
    localparam int         COM_HI_BIT        = 5;
    localparam int         COM_LO_BIT        = 4;
    localparam logic [7:0] TOP_MAX           = 8'hFF;
    localparam logic [7:0] BOTTOM            = 8'h00;

    // ------------------------------------------------------------
    // Prescaler taps
    // ------------------------------------------------------------
    localparam int         PRESC_W           = 10;
    localparam logic [9:0] DIV8_MASK         = 10'h007;
    localparam logic [9:0] DIV64_MASK        = 10'h03F;
    localparam logic [9:0] DIV256_MASK       = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK      = 10'h3FF;

    typedef enum logic [1:0] {
        TMR8_WG_NORMAL,
        TMR8_WG_PHASE,
        TMR8_WG_CTC,
        TMR8_WG_FAST
    } tmr8_wave_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tmr8_io_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } tmr8_io_rsp_t;
endpackage : tmr8_pkg

// >>> tmr8_timer.sv
// Purpose: 8-bit timer with compare, flags, mask and output modulator
// Assumes: CPU I/O strobes on clk_i; vector acks are one-cycle pulses
// Notes:   Compare output mode logic reduced to enable and toggle-style output
`timescale 1ns/1ps

module tmr8_timer (
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  tmr8_pkg::tmr8_io_req_t     io_req_i,
    output tmr8_pkg::tmr8_io_rsp_t     io_rsp_o,
    input  wire logic                  ext_count_pin_i,
    input  wire logic                  global_irq_en_i,
    input  wire logic                  compare_vec_ack_i,
    input  wire logic                  overflow_vec_ack_i,
    input  wire logic                  compare_out_a_i,
    input  wire logic                  compare_out_a_en_i,
    input  wire logic                  port_latch_bit_i,
    input  wire logic                  legacy_mode_i,
    output logic                       compare_irq_o,
    output logic                       overflow_irq_o,
    output logic                       compare_out_b_o,
    output logic                       compare_out_pin_o,
    output logic                       compare_out_pin_en_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] compare_match_value;
        logic [7:0] ctrl;
        logic       compare_flag;
        logic       overflow_flag;
        logic       compare_irq_enable;
        logic       overflow_irq_enable;
        logic       down;
        logic       block_match;
        logic       wave_b;
        logic       pin;
        logic       pin_en;
        logic [7:0] rdata;
        logic       rvalid;
    } tmr8_state_t;

    tmr8_state_t         s_q, s_d;
    logic                tick;
    tmr8_pkg::tmr8_wave_t mode;
    logic [7:0]          top;
    logic                match;
    logic                ovf_evt;
    logic                cmp_evt;
    logic [1:0]          com;
    logic                mod_on;

    tmr8_clk_src u_clk_src (
        .clk_i           (clk_i),
        .arst_n_i        (arst_n_i),
        .clock_select_i  (s_q.ctrl[2:0]),
        .ext_count_pin_i (ext_count_pin_i),
        .tick_o          (tick)
    );

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        mode   = tmr8_pkg::tmr8_wave_t'({s_q.ctrl[tmr8_pkg::WGM_HI_BIT],
                                         s_q.ctrl[tmr8_pkg::WGM_LO_BIT]});
        top    = (mode == tmr8_pkg::TMR8_WG_CTC) ? s_q.compare_match_value
                                                 : tmr8_pkg::TOP_MAX;
        com    = {s_q.ctrl[tmr8_pkg::COM_HI_BIT], s_q.ctrl[tmr8_pkg::COM_LO_BIT]};
        match  = tick && !s_q.block_match
                 && (s_q.count == s_q.compare_match_value);
        cmp_evt = match;
        ovf_evt = 1'b0;
        if (tick) begin
            s_d.block_match = 1'b0;
            if (mode == tmr8_pkg::TMR8_WG_PHASE) begin
                if (!s_q.down) begin
                    if (s_q.count == top) begin
                        s_d.down  = 1'b1;
                        s_d.count = s_q.count - 8'h01;
                    end else begin
                        s_d.count = s_q.count + 8'h01;
                    end
                end else if (s_q.count == tmr8_pkg::BOTTOM) begin
                    s_d.down  = 1'b0;
                    s_d.count = s_q.count + 8'h01;
                    ovf_evt   = 1'b1;
                end else begin
                    s_d.count = s_q.count - 8'h01;
                end
            end else if (s_q.count == top) begin
                s_d.count = tmr8_pkg::BOTTOM;
                s_d.down  = 1'b0;
                ovf_evt   = (s_q.count == tmr8_pkg::TOP_MAX);
            end else begin
                s_d.count = s_q.count + 8'h01;
                s_d.down  = 1'b0;
                // Count written above top still wraps at max
                ovf_evt   = (s_q.count == tmr8_pkg::TOP_MAX);
            end
        end
        if (match && com != 2'h0) begin
            s_d.wave_b = ~s_q.wave_b;
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        s_d.rvalid = io_req_i.rd;
        s_d.rdata  = tmr8_pkg::REG_RESET;
        if (io_req_i.wr) begin
            if (io_req_i.addr == tmr8_pkg::COMPARE_VALUE_OFS) begin
                s_d.compare_match_value = io_req_i.wdata;
            end else if (io_req_i.addr == tmr8_pkg::COUNTER_VALUE_OFS) begin
                s_d.count       = io_req_i.wdata;
                s_d.block_match = 1'b1;
            end else if (io_req_i.addr == tmr8_pkg::CONTROL_OFS) begin
                s_d.ctrl = io_req_i.wdata & 8'h7F;
            end else if (io_req_i.addr == tmr8_pkg::IRQ_MASK_OFS) begin
                s_d.compare_irq_enable  = io_req_i.wdata[tmr8_pkg::CMP_BIT];
                s_d.overflow_irq_enable = io_req_i.wdata[tmr8_pkg::OVF_BIT];
            end
        end

        // --------------------------------------------------------
        // Flags: set wins over either clear
        // --------------------------------------------------------
        if (io_req_i.wr && io_req_i.addr == tmr8_pkg::IRQ_FLAGS_OFS) begin
            if (io_req_i.wdata[tmr8_pkg::CMP_BIT]) begin
                s_d.compare_flag = 1'b0;
            end
            if (io_req_i.wdata[tmr8_pkg::OVF_BIT]) begin
                s_d.overflow_flag = 1'b0;
            end
        end
        if (compare_vec_ack_i) begin
            s_d.compare_flag = 1'b0;
        end
        if (overflow_vec_ack_i) begin
            s_d.overflow_flag = 1'b0;
        end
        if (cmp_evt) begin
            s_d.compare_flag = 1'b1;
        end
        if (ovf_evt) begin
            s_d.overflow_flag = 1'b1;
        end

        // --------------------------------------------------------
        // Register reads
        // --------------------------------------------------------
        if (io_req_i.rd) begin
            if (io_req_i.addr == tmr8_pkg::COMPARE_VALUE_OFS) begin
                s_d.rdata = s_q.compare_match_value;
            end else if (io_req_i.addr == tmr8_pkg::COUNTER_VALUE_OFS) begin
                s_d.rdata = s_q.count;
            end else if (io_req_i.addr == tmr8_pkg::CONTROL_OFS) begin
                s_d.rdata = s_q.ctrl;
            end else if (io_req_i.addr == tmr8_pkg::IRQ_FLAGS_OFS) begin
                s_d.rdata = {s_q.compare_flag, s_q.overflow_flag, 6'h00};
            end else if (io_req_i.addr == tmr8_pkg::IRQ_MASK_OFS) begin
                s_d.rdata = {s_q.compare_irq_enable, s_q.overflow_irq_enable, 6'h00};
            end
        end

        // --------------------------------------------------------
        // Output modulator
        // --------------------------------------------------------
        // Fuse mode wins: legacy parts have no modulator
        mod_on = compare_out_a_en_i && (com != 2'h0) && !legacy_mode_i;
        if (mod_on) begin
            s_d.pin = port_latch_bit_i ? (compare_out_a_i | s_q.wave_b)
                                       : (compare_out_a_i & s_q.wave_b);
        end else if (com != 2'h0) begin
            s_d.pin = s_q.wave_b;
        end else if (compare_out_a_en_i) begin
            s_d.pin = compare_out_a_i;
        end else begin
            s_d.pin = port_latch_bit_i;
        end
        s_d.pin_en = (com != 2'h0) || compare_out_a_en_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rsp_o             = '{valid: s_q.rvalid, rdata: s_q.rdata};
    assign compare_irq_o        = s_q.compare_irq_enable & global_irq_en_i
                                  & s_q.compare_flag;
    assign overflow_irq_o       = s_q.overflow_irq_enable & global_irq_en_i
                                  & s_q.overflow_flag;
    assign compare_out_b_o      = s_q.wave_b;
    assign compare_out_pin_o    = s_q.pin;
    assign compare_out_pin_en_o = s_q.pin_en;
endmodule : tmr8_timer

// >>> tmr8_timer_chk.sv
// Purpose: Port assertions for the 8-bit timer
// Assumes: Bound to tmr8_timer; irq outputs are combinational
// Notes:   Modulator checks only where both mode choices agree
`timescale 1ns/1ps
module tmr8_chk (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  tmr8_pkg::tmr8_io_req_t io_req_i,
    input  tmr8_pkg::tmr8_io_rsp_t io_rsp_o,
    input  wire logic             global_irq_en_i,
    input  wire logic             compare_vec_ack_i,
    input  wire logic             overflow_vec_ack_i,
    input  wire logic             compare_out_a_i,
    input  wire logic             compare_out_a_en_i,
    input  wire logic             port_latch_bit_i,
    input  wire logic             legacy_mode_i,
    input  wire logic             compare_irq_o,
    input  wire logic             overflow_irq_o,
    input  wire logic             compare_out_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_cmp_irq; compare_irq_o |-> global_irq_en_i; endproperty
    property p_ovf_irq; overflow_irq_o |-> global_irq_en_i; endproperty
    property p_rd_valid; io_req_i.rd |=> io_rsp_o.valid; endproperty
    property p_valid_src; io_rsp_o.valid |-> $past(io_req_i.rd); endproperty
    property p_cmp_hold;
        compare_irq_o && !compare_vec_ack_i && !io_req_i.wr |=> compare_irq_o || !global_irq_en_i;
    endproperty
    property p_ovf_hold;
        overflow_irq_o && !overflow_vec_ack_i && !io_req_i.wr |=> overflow_irq_o || !global_irq_en_i;
    endproperty
    property p_mod_or;
        !legacy_mode_i && compare_out_a_en_i && port_latch_bit_i && compare_out_a_i
            |=> compare_out_pin_o;
    endproperty
    property p_mod_and;
        !legacy_mode_i && compare_out_a_en_i && !port_latch_bit_i && !compare_out_a_i
            |=> !compare_out_pin_o;
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq without enable");
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without enable");
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    a_valid_src: assert property (p_valid_src) else $error("answer without read");
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare flag lost");
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
    a_mod_or: assert property (p_mod_or) else $error("OR modulation wrong");
    a_mod_and: assert property (p_mod_and) else $error("AND modulation wrong");
    c_cmp: cover property (compare_irq_o);
    c_ovf: cover property (overflow_irq_o);
    c_mod: cover property (compare_out_a_en_i && compare_out_pin_o);
endmodule : tmr8_chk

bind tmr8_timer tmr8_chk tmr8_chk_i (.clk_i, .arst_n_i, .io_req_i, .io_rsp_o,
    .global_irq_en_i, .compare_vec_ack_i, .overflow_vec_ack_i, .compare_out_a_i,
    .compare_out_a_en_i, .port_latch_bit_i, .legacy_mode_i, .compare_irq_o,
    .overflow_irq_o, .compare_out_pin_o);
